// ===== core/ubp_burst_timing.sv
// Module: stores burst profiles and user parameters, launches granted bursts on time
`timescale 1ns/1ps
module ubp_burst_timing
  import ubp_pkg::*;
#(
  parameter int NUM_TYPES = 16,
  parameter int TYPE_W    = 4
) (
  input  wire logic                clk,
  input  wire logic                rst,
  // Upstream frame time in units of tick/64, supplied from outside the block
  input  wire logic [31:0]         frame_units,
  input  wire ubp_chan_type        chan_cfg,
  input  wire logic                chan_wr,
  input  wire logic                pre_wr,
  input  wire logic [9:0]          pre_addr,
  input  wire logic                pre_bit,
  input  wire logic                prof_wr,
  input  wire logic [TYPE_W-1:0]   prof_sel,
  input  wire ubp_prof_type        prof_cfg,
  input  wire logic                user_wr,
  input  wire ubp_user_type        user_cfg,
  input  wire logic                rng_load,
  input  wire logic [15:0]         rng_value,
  input  wire logic                rng_adj,
  input  wire logic signed [16:0]  rng_delta,
  input  wire logic                eq_wr,
  input  wire logic [5:0]          eq_addr,
  input  wire logic [31:0]         eq_coef,
  input  wire logic                grant_valid,
  output logic                     grant_ready,
  input  wire ubp_grant_type       grant,
  output logic                     burst_start,
  output logic                     burst_active,
  output ubp_prof_type             active_prof,
  output ubp_user_type             active_user,
  output ubp_chan_type             active_chan,
  output logic [7:0]               active_slots,
  output logic [7:0]               last_cw_bytes,
  output logic                     fec_on,
  output logic                     reconf_needed,
  output logic [15:0]              rng_offset,
  output logic                     pre_out,
  input  wire logic [9:0]          pre_rd_addr,
  output logic [31:0]              eq_rd_coef,
  input  wire logic                burst_done,
  output logic                     cfg_error
);

  ubp_chan_type       chan_q;
  logic [1023:0]      pre_q;
  ubp_prof_type       prof_q [NUM_TYPES];
  ubp_user_type       user_q;
  logic [15:0]        rng_q;
  logic [31:0]        eq_q [EQ_TAPS];
  ubp_grant_type      pend_q;
  logic               pend_valid_q;
  logic               active_q;
  logic               start_q;
  logic               reconf_q;
  logic               cfg_err_q;
  ubp_prof_type       aprof_q;
  ubp_user_type       auser_q;
  ubp_chan_type       achan_q;
  logic [15:0]        arng_q;
  logic [7:0]         aslots_q;
  logic [7:0]         lastcw_q;
  logic [6:0]         sym_units;
  logic [15:0]        rng_rounded;
  logic [31:0]        launch_units;
  logic               launch;
  ubp_prof_type       gprof;
  logic [7:0]         gslots;
  logic               changed;

  // Units of tick/64 in one symbol at the given rate
  function automatic logic [6:0] units_per_sym(input ubp_rate_type r);
    units_per_sym = UNITS_PER_SYM_SLOWEST >> r;
  endfunction

  // Range checks per field; a zero strength skips the codeword size check
  function automatic logic prof_ok(input ubp_prof_type p);
    logic pre_step;
    logic pre_ok;
    logic fec_ok;
    logic guard_ok;
    pre_step = (p.mod == MOD_QAM16) ? (p.pre_len[1:0] == 2'h0) : (p.pre_len[0] == 1'b0);
    pre_ok   = (p.pre_len <= PRE_LEN_MAX) && (p.pre_off <= PRE_OFF_MAX) && pre_step;
    fec_ok   = (p.fec_t <= FEC_T_MAX)
               && ((p.fec_t == 4'h0) || ((p.fec_k >= K_MIN) && (p.fec_k <= K_MAX)));
    guard_ok = (p.guard_sym >= GUARD_MIN);
    prof_ok  = pre_ok && fec_ok && guard_ok;
  endfunction

  // Sum kept two bits wider than the offset so the top end cannot wrap before the clamp
  function automatic logic [15:0] rng_sat(input logic [15:0] cur, input logic signed [16:0] delta);
    logic signed [17:0] sum;
    sum = $signed({2'b00, cur}) + 18'(delta);
    if (sum < 18'sh00000) begin
      rng_sat = 16'h0000;
    end else if (sum > 18'sh0FFFF) begin
      rng_sat = 16'hFFFF;
    end else begin
      rng_sat = sum[15:0];
    end
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      chan_q <= '0;
    end else if (chan_wr) begin
      chan_q <= chan_cfg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_q <= '0;
    end else if (pre_wr) begin
      pre_q[pre_addr] <= pre_bit;
    end
  end

  // Profiles rejected when out of range so a bad descriptor cannot corrupt a live type
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_TYPES; i++) prof_q[i] <= '0;
    end else if (prof_wr && prof_ok(prof_cfg)) begin
      prof_q[prof_sel] <= prof_cfg;
    end
  end

  // User values kept apart from the shared profiles
  always_ff @(posedge clk) begin
    if (rst) begin
      user_q <= '0;
    end else if (user_wr) begin
      user_q <= user_cfg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_err_q <= 1'b0;
    end else if (prof_wr && !prof_ok(prof_cfg)) begin
      cfg_err_q <= 1'b1;
    end else if (user_wr) begin
      cfg_err_q <= (user_cfg.power_dbmv < PWR_MIN)
                   || (user_cfg.power_dbmv > PWR_MAX_QPSK)
                   || (user_cfg.foff_hz > FOFF_MAX) || (user_cfg.foff_hz < -FOFF_MAX);
    end
  end

  // Saturating so a large correction never wraps the offset
  always_ff @(posedge clk) begin
    if (rst) begin
      rng_q <= RNG_RESET;
    end else if (rng_load) begin
      rng_q <= rng_value;
    end else if (rng_adj) begin
      rng_q <= rng_sat(rng_q, rng_delta);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < EQ_TAPS; i++) eq_q[i] <= '0;
    end else if (eq_wr) begin
      eq_q[eq_addr] <= eq_coef;
    end
  end

  // Offset used for timing is rounded to whole symbols at the burst's rate
  assign sym_units    = units_per_sym(chan_q.rate);
  assign rng_rounded  = rng_q & ~{9'h000, 7'(sym_units - 7'h01)};
  assign launch_units = 32'(pend_q.start_units - {16'h0000, rng_rounded});
  assign launch       = pend_valid_q && !active_q && ($signed(frame_units - launch_units) >= 0);
  assign gprof        = prof_q[pend_q.burst_type[TYPE_W-1:0]];
  assign gslots       = (gprof.max_slots == 8'h00) ? pend_q.length_slots : gprof.max_slots;
  assign changed      = (gprof.mod != aprof_q.mod) || (user_q != auser_q) || (chan_q != achan_q)
                        || (rng_rounded != arng_q);
  assign grant_ready  = !pend_valid_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q       <= '0;
      pend_valid_q <= 1'b0;
    end else if (grant_valid && grant_ready) begin
      pend_q       <= grant;
      pend_valid_q <= 1'b1;
    end else if (launch) begin
      pend_valid_q <= 1'b0;
    end
  end

  // Snapshot at launch: settings applied from the first symbol
  always_ff @(posedge clk) begin
    if (rst) begin
      aprof_q  <= '0;
      auser_q  <= '0;
      achan_q  <= '0;
      arng_q   <= '0;
      aslots_q <= '0;
      lastcw_q <= '0;
      reconf_q <= 1'b0;
    end else if (launch) begin
      aprof_q  <= gprof;
      auser_q  <= user_q;
      achan_q  <= chan_q;
      arng_q   <= rng_rounded;
      aslots_q <= gslots;
      reconf_q <= changed;
      lastcw_q <= gprof.last_short ? 8'h00 : gprof.fec_k;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      active_q <= 1'b0;
      start_q  <= 1'b0;
    end else begin
      start_q <= launch;
      if (launch) begin
        active_q <= 1'b1;
      end else if (burst_done) begin
        active_q <= 1'b0;
      end
    end
  end

  assign burst_start   = start_q;
  assign burst_active  = active_q;
  assign active_prof   = aprof_q;
  assign active_user   = auser_q;
  assign active_chan   = achan_q;
  assign active_slots  = aslots_q;
  // Zero means the datapath shortens to the remaining bytes
  assign last_cw_bytes = lastcw_q;
  assign fec_on        = (aprof_q.fec_t != 4'h0);
  assign reconf_needed = reconf_q;
  assign rng_offset    = rng_q;
  assign pre_out       = pre_q[pre_rd_addr];
  assign eq_rd_coef    = eq_q[eq_addr];
  assign cfg_error     = cfg_err_q;
endmodule

// ===== core/ubp_pkg.sv
// Package: constants and carrier types for the upstream burst profile and timing block
// Notes on behaviour
// - Channel: five doubling symbol rates, frequency, preamble
// - Profile FEC strength 0..10, zero disables
// - Codeword info bytes 16..253, fixed/shortened mode
// - Preamble length 0..1024, offset 0..1022
// - Max burst 0..255 slots, zero means variable
// - Variable burst length 1..255 per grant
// - Power 8..55 (16QAM) or 8..58 (QPSK); the user check applies 8..58 for both
// - Offset frequency +-32 kHz in 1 Hz
// - Ranging offset unsigned 16 bit, tick/64
// - Up to 64 equalizer coefficients, 4 bytes
// - Start burst at granted mini-slot time
// - Support every defined and granted profile
// - Advance transmit timing by ranging offset
// - Negative adjustment lowers offset, transmits later
// - Correction resolution at most one symbol
// - Back-to-back unless listed parameters change
// - Per-user parameters kept apart from profiles
// - Shortened mode shortens final codeword
// - 96 symbol gap when key parameters change; the block only raises reconf_needed and times no gap
package ubp_pkg;
  localparam int NUM_RATES      = 5;
  localparam int RATE_W         = 3;
  localparam logic [3:0] FEC_T_MAX       = 4'hA;
  localparam logic [7:0] K_MIN           = 8'h10;
  localparam logic [7:0] K_MAX           = 8'hFD;
  localparam logic [10:0] PRE_LEN_MAX    = 11'h400;
  localparam logic [9:0] PRE_OFF_MAX     = 10'h3FE;
  localparam logic [5:0] PWR_MIN         = 6'h08;
  localparam logic [5:0] PWR_MAX_QAM16   = 6'h37;
  localparam logic [5:0] PWR_MAX_QPSK    = 6'h3A;
  localparam logic signed [16:0] FOFF_MAX = 17'sh07D00;
  localparam int EQ_TAPS        = 64;
  localparam int RECONF_SYMBOLS = 96;
  // Sub-tick unit: 6.25 us / 64 = 97.65625 ns; one 160 ksym/s symbol = 64 units
  localparam logic [6:0] UNITS_PER_SYM_SLOWEST = 7'h40;
  localparam logic [15:0] RNG_RESET = 16'h0000;
  localparam logic [7:0] GUARD_MIN       = 8'h04;

  typedef enum logic [RATE_W-1:0] {RATE_160K, RATE_320K, RATE_640K, RATE_1280K, RATE_2560K} ubp_rate_type;
  typedef enum logic {MOD_QPSK, MOD_QAM16} ubp_mod_type;

  typedef struct packed {
    ubp_rate_type rate;
    logic [31:0]  centre_hz;
  } ubp_chan_type;

  typedef struct packed {
    ubp_mod_type mod;
    logic        diff_en;
    logic [10:0] pre_len;
    logic [9:0]  pre_off;
    logic [3:0]  fec_t;
    logic [7:0]  fec_k;
    logic [14:0] seed;
    logic        scr_en;
    logic [7:0]  max_slots;
    logic [7:0]  guard_sym;
    logic        last_short;
  } ubp_prof_type;

  typedef struct packed {
    logic [5:0]         power_dbmv;
    logic signed [16:0] foff_hz;
    logic [7:0]         burst_slots;
  } ubp_user_type;

  typedef struct packed {
    logic [31:0] start_units;
    logic [3:0]  burst_type;
    logic [7:0]  length_slots;
  } ubp_grant_type;
endpackage

// ===== testbench/ubp_headend.sv
// Headend model: issues one mini-slot grant per request
`timescale 1ns/1ps
module ubp_headend
  import ubp_pkg::*;
(
  input wire logic          clk,
  input wire logic          send,
  input wire ubp_grant_type next_grant,
  input wire logic          grant_ready,
  output logic              grant_valid,
  output ubp_grant_type     grant
);
  initial grant_valid = 1'b0;
  initial grant = '0;
  // Released grant lines are bit-inverted so stale values cannot pass
  always @(posedge clk) begin
    if (grant_valid && grant_ready) begin
      grant_valid <= 1'b0;
      grant <= ~grant;
    end else if (send && !grant_valid) begin
      grant_valid <= 1'b1;
      grant <= next_grant;
    end
  end
endmodule

// ===== testbench/ubp_props.sv
// Checker for grant, launch, ranging and snapshot behaviour
`timescale 1ns/1ps
module ubp_props
  import ubp_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               grant_valid,
  input wire logic               grant_ready,
  input wire logic               burst_start,
  input wire logic               burst_active,
  input wire logic               burst_done,
  input wire logic               rng_load,
  input wire logic [15:0]        rng_value,
  input wire logic               rng_adj,
  input wire logic signed [16:0] rng_delta,
  input wire logic [15:0]        rng_offset,
  input wire logic               fec_on,
  input wire ubp_prof_type       active_prof
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_take;
    grant_valid && grant_ready;
  endsequence
  sequence s_launch;
    burst_start && burst_active;
  endsequence
  property p_take;
    s_take |=> !grant_ready;
  endproperty
  a_take: assert property (p_take) else $error("second grant accepted");
  property p_pulse;
    burst_start |-> s_launch ##1 !burst_start;
  endproperty
  a_pulse: assert property (p_pulse) else $error("burst start malformed");
  property p_done;
    burst_done && burst_active |=> !burst_active;
  endproperty
  a_done: assert property (p_done) else $error("burst not ended");
  property p_load;
    rng_load && !rng_adj |=> rng_offset == $past(rng_value);
  endproperty
  a_load: assert property (p_load) else $error("ranging load lost");
  property p_neg;
    rng_adj && !rng_load && rng_delta < 0 |=> rng_offset < $past(rng_offset) || rng_offset == 16'h0000;
  endproperty
  a_neg: assert property (p_neg) else $error("negative step wrong");
  property p_pos;
    rng_adj && !rng_load && rng_delta > 0 |=> rng_offset > $past(rng_offset) || rng_offset == 16'hFFFF;
  endproperty
  a_pos: assert property (p_pos) else $error("positive step wrong");
  property p_fec;
    fec_on == (active_prof.fec_t != 4'h0) && active_prof.fec_t <= FEC_T_MAX;
  endproperty
  a_fec: assert property (p_fec) else $error("fec enable wrong");
  property p_snap;
    $changed(active_prof) |-> burst_start;
  endproperty
  a_snap: assert property (p_snap) else $error("profile moved mid burst");
endmodule
bind ubp_burst_timing ubp_props ubp_props_i (.clk(clk), .rst(rst), .grant_valid(grant_valid),
  .grant_ready(grant_ready), .burst_start(burst_start), .burst_active(burst_active), .burst_done(burst_done),
  .rng_load(rng_load), .rng_value(rng_value), .rng_adj(rng_adj), .rng_delta(rng_delta),
  .rng_offset(rng_offset), .fec_on(fec_on), .active_prof(active_prof));

// ===== testbench/upstream_burst_profile_timing_bench.sv
// Self-checking bench for profile storage, ranging and grant timing
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; $display("Error %0t: mismatch", $time); end end
module upstream_burst_profile_timing_bench;
  import ubp_pkg::*;
  logic clk, rst, chan_wr, pre_wr, pre_bit, prof_wr, user_wr, rng_load, rng_adj, eq_wr, burst_done, send;
  logic grant_valid, grant_ready, burst_start, burst_active, fec_on, reconf_needed, pre_out, cfg_error;
  logic [31:0]        frame_units, eq_coef, eq_rd_coef, s;
  logic [9:0]         pre_addr, pre_rd_addr;
  logic [3:0]         prof_sel;
  logic [15:0]        rng_value, rng_offset;
  logic signed [16:0] rng_delta;
  logic [5:0]         eq_addr;
  logic [7:0]         active_slots, last_cw_bytes;
  ubp_chan_type       chan_cfg, active_chan, c, pc;
  ubp_prof_type       prof_cfg, active_prof, p;
  ubp_user_type       user_cfg, active_user, u, pu;
  ubp_grant_type      grant, next_grant;
  ubp_mod_type        pm;
  int                 seed, fail_count, tests_run, cyc, rng_m, rr, got, t, prr;
  ubp_burst_timing ubp_burst_timing_i (.clk, .rst, .frame_units, .chan_cfg, .chan_wr, .pre_wr, .pre_addr, .pre_bit,
    .prof_wr, .prof_sel, .prof_cfg, .user_wr, .user_cfg, .rng_load, .rng_value, .rng_adj, .rng_delta, .eq_wr,
    .eq_addr, .eq_coef, .grant_valid, .grant_ready, .grant, .burst_start, .burst_active, .active_prof,
    .active_user, .active_chan, .active_slots, .last_cw_bytes, .fec_on, .reconf_needed, .rng_offset, .pre_out,
    .pre_rd_addr, .eq_rd_coef, .burst_done, .cfg_error);
  ubp_headend ubp_headend_i (.clk, .send, .next_grant, .grant_ready, .grant_valid, .grant);
  always #2.5 clk = ~clk;
  function automatic int rn(int n);
    return {$random(seed)} % n;
  endfunction
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
  endtask
  task automatic stop_test();
    if (fail_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic rng_op(logic ld, logic [15:0] v, int d);
    rng_load <= ld;
    rng_adj <= !ld;
    rng_value <= v;
    rng_delta <= 17'(d);
    tick();
    rng_load <= 1'b0;
    rng_adj <= 1'b0;
    rng_m = ld ? v : (rng_m + d < 0 ? 0 : (rng_m + d > 65535 ? 65535 : rng_m + d));
    tick();
    `CHK(rng_offset, 16'(rng_m))
  endtask
  task automatic put_user(logic [5:0] pw, int len);
    u = {pw, 17'(rn(64001) - 32000), 8'(len)};
    user_cfg <= u;
    user_wr <= 1'b1;
  endtask
  initial begin
    {clk, chan_wr, pre_wr, pre_bit, prof_wr, user_wr, rng_load, rng_adj, eq_wr, burst_done, send} = '0;
    {frame_units, eq_coef, pre_addr, pre_rd_addr, prof_sel, rng_value, rng_delta, eq_addr} = '0;
    {chan_cfg, prof_cfg, user_cfg, next_grant, pc, pu} = '0;
    pm = MOD_QPSK;
    seed = 62;
    rst = 1'b1;
    tick(10);
    rst <= 1'b0;
    tick();
    `CHK(grant_ready, 1'b1)
    rng_op(1'b1, 16'h0005, 0);
    rng_op(1'b0, 16'h0000, -9);
    rng_op(1'b0, 16'h0000, 40);
    rng_op(1'b1, 16'hFFF0, 0);
    rng_op(1'b0, 16'h0000, 32);
    for (int i = 0; i < 10; i++) begin
      t = i % 4;
      c = {ubp_rate_type'(i % 5), 32'(rn(60000000))};
      // Last pass repeats the modulation, user, channel and ranging settings so no reconfiguration is due
      if (i == 9) c = pc;
      p = ubp_prof_type'(68'({$random(seed), $random(seed), $random(seed)}));
      p.fec_t = 4'(rn(11));
      p.fec_k = 8'(16 + rn(238));
      p.pre_len = 11'(4 * rn(257));
      p.pre_off = 10'(rn(1023));
      p.guard_sym = 8'(4 + rn(252));
      if (i % 2) p.max_slots = 8'h00;
      if (i == 9) p.mod = pm;
      if (i < 9)
        put_user(6'(8 + rn(51)), 1 + rn(255));
      else
        u = pu;
      rng_m = (i < 9) ? rn(65536) : prr;
      rr = rng_m & ~((64 >> c.rate) - 1);
      chan_cfg <= c;
      chan_wr <= 1'b1;
      prof_cfg <= p;
      prof_sel <= 4'(t);
      prof_wr <= 1'b1;
      rng_value <= 16'(rng_m);
      rng_load <= 1'b1;
      pre_addr <= 10'(i * 97);
      pre_rd_addr <= 10'(i * 97);
      pre_bit <= i[0];
      pre_wr <= 1'b1;
      eq_addr <= 6'(i * 5);
      eq_coef <= 32'(i * 32'h01234567);
      eq_wr <= 1'b1;
      tick();
      {chan_wr, prof_wr, user_wr, rng_load, pre_wr, eq_wr} <= '0;
      s = 32'(100000 + rn(100000));
      frame_units <= s - 32'(rr) - 32'h1;
      next_grant <= {s, 4'(t), u.burst_slots};
      send <= 1'b1;
      tick();
      send <= 1'b0;
      `CHK(eq_rd_coef, 32'(i * 32'h01234567))
      `CHK(rng_offset, 16'(rng_m))
      `CHK(cfg_error, 1'b0)
      `CHK(pre_out, 1'(i % 2))
      tick(4);
      `CHK(burst_active, 1'b0)
      frame_units <= s - 32'(rr);
      got = 0;
      repeat (4) begin
        tick();
        if (burst_start === 1'b1) got = 1;
      end
      `CHK(got, 1)
      `CHK(active_prof, p)
      `CHK(active_slots, p.max_slots == 8'h00 ? u.burst_slots : p.max_slots)
      `CHK(fec_on, p.fec_t != 4'h0)
      `CHK(active_user, u)
      `CHK(active_chan, c)
      `CHK(reconf_needed, (p.mod != pm) || (u != pu) || (c != pc) || (rr != prr))
      `CHK(last_cw_bytes, p.last_short ? 8'h00 : p.fec_k)
      pu = u;
      pc = c;
      pm = p.mod;
      prr = rr;
      burst_done <= 1'b1;
      tick();
      burst_done <= 1'b0;
      tick(2);
      `CHK(burst_active, 1'b0)
    end
    pre_wr <= 1'b1;
    pre_bit <= 1'b1;
    tick();
    pre_wr <= 1'b0;
    tick();
    `CHK(pre_out, 1'b1)
    p.fec_t = 4'hB;
    prof_cfg <= p;
    prof_wr <= 1'b1;
    tick();
    prof_wr <= 1'b0;
    tick();
    `CHK(cfg_error, 1'b1)
    put_user(6'h3B, 9);
    tick();
    user_wr <= 1'b0;
    tick();
    `CHK(cfg_error, 1'b1)
    stop_test();
  end
endmodule
